// file: bench/cpwg_host.sv
/* host model for cpwg_top: index and data port cycles.
   assumes the bench calls its tasks only after reset release. */
`timescale 1ns/1ps
`default_nettype none
module cpwg_host (
    input  wire logic       clk_i,       // chip clock
    input  wire logic [7:0] io_rdata_i,  // read data
    input  wire logic       io_rvalid_i, // read valid
    output var  logic [7:0] io_addr_o,   // port address
    output var  logic       io_wr_o,     // write strobe
    output var  logic       io_rd_o,     // read strobe
    output var  logic [7:0] io_wdata_o   // write data
);
initial begin
    io_addr_o = 8'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
end
// ==========================================================
// bus cycles; released lines show the inverse, not the old value
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
endtask
task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    d = io_rvalid_i ? io_rdata_i : 8'hxx;
endtask
// ==========================================================
// configuration access: index first, then data
task unlock;
    wr(8'h2e, 8'h87);
    wr(8'h2e, 8'h87);
endtask
task cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    wr(8'h2e, idx);
    wr(8'h2f, v);
endtask
task cfg_rd(input logic [7:0] idx, output logic [7:0] d);
    wr(8'h2e, idx);
    rd(8'h2f, d);
endtask
task sel(input logic [7:0] ld);
    cfg_wr(8'h07, ld);
endtask
endmodule
`default_nettype wire

// file: bench/cpwg_top_assertions.sv
/* port checker for cpwg_top: host port answers, lock state, expiry pulse.
   assumes a bind from the bench onto every cpwg_top instance. */
`timescale 1ns/1ps
`default_nettype none
module cpwg_top_assertions (
    input wire logic       clk_i,                  // chip clock
    input wire logic       reset_n_i,              // async reset
    input wire logic [7:0] io_addr_i,              // host address
    input wire logic       io_wr_i,                // write strobe
    input wire logic       io_rd_i,                // read strobe
    input wire logic [7:0] io_wdata_i,             // write data
    input wire logic [7:0] io_rdata_o,             // read data
    input wire logic       io_rvalid_o,            // read valid
    input wire logic       guard_expiry_output_n_o // system reset
);
// ==========================================================
// shadow of lock state, index, device and pulse length
logic       key_r;
logic       unl_r;
logic [7:0] idx_r;
logic [7:0] ld_r;
logic [4:0] low_cnt_r;
wire        idx_wr = io_wr_i && io_addr_i == 8'h2e;
always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        key_r <= 1'b0;
        unl_r <= 1'b0;
        idx_r <= 8'h00;
        ld_r <= 8'h00;
        low_cnt_r <= 5'h00;
    end else begin
        if (io_wr_i) key_r <= idx_wr && io_wdata_i == 8'h87 && !unl_r;
        if (idx_wr && !unl_r && key_r && io_wdata_i == 8'h87) unl_r <= 1'b1;
        else if (idx_wr && unl_r && io_wdata_i == 8'haa) unl_r <= 1'b0;
        if (idx_wr && unl_r && io_wdata_i != 8'haa) idx_r <= io_wdata_i;
        if (io_wr_i && io_addr_i == 8'h2f && unl_r && idx_r == 8'h07) ld_r <= io_wdata_i;
        low_cnt_r <= guard_expiry_output_n_o ? 5'h00 : low_cnt_r + 5'h01;
    end
end
// ==========================================================
// properties
default clocking cb @(posedge clk_i); endclocking
default disable iff (!reset_n_i);
property p_rvalid_pulse; io_rd_i |=> io_rvalid_o; endproperty
a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read unanswered");
property p_rvalid_idle; !io_rd_i |=> !io_rvalid_o; endproperty
a_rvalid_idle: assert property (p_rvalid_idle) else $error("stray valid");
property p_rdata_hold; !io_rd_i |=> $stable(io_rdata_o); endproperty
a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
property p_locked_read;
    io_rd_i && !unl_r && (io_addr_i == 8'h2e || io_addr_i == 8'h2f) |=> io_rdata_o == 8'hff;
endproperty
a_locked_read: assert property (p_locked_read) else $error("locked read leaked");
property p_index_read; io_rd_i && unl_r && io_addr_i == 8'h2e |=> io_rdata_o == $past(idx_r);
endproperty
a_index_read: assert property (p_index_read) else $error("index readback wrong");
property p_ld_read;
    io_rd_i && unl_r && io_addr_i == 8'h2f && idx_r == 8'h07 |=> io_rdata_o == $past(ld_r);
endproperty
a_ld_read: assert property (p_ld_read) else $error("device select wrong");
property p_expiry_len; $rose(guard_expiry_output_n_o) |-> low_cnt_r == 5'd16; endproperty
a_expiry_len: assert property (p_expiry_len) else $error("expiry pulse length");
property p_expiry_cap; low_cnt_r <= 5'd16; endproperty
a_expiry_cap: assert property (p_expiry_cap) else $error("expiry pulse too long");
endmodule
`default_nettype wire

// file: bench/testbench.sv
/* self-checking bench for cpwg_top: access table, then pins, guard, reset.
   assumes cpwg_host drives the host ports and a short unit tick. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
// ==========================================================
// signals
typedef struct packed {
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
} cpwg_op_t;
logic       clk_i;
logic       reset_n_i = 1'b0;
logic [7:0] io_addr_i;
logic       io_wr_i;
logic       io_rd_i;
logic [7:0] io_wdata_i;
logic [7:0] io_rdata_o;
logic       io_rvalid_o;
logic       g_n;
logic [1:0] dio_o;
logic [1:0] dio_oe;
logic [7:0] led_o;
logic [7:0] led_oe;
logic [5:0] dio_in = 6'h2d;
logic [7:0] led_in = 8'ha5;
logic [7:0] rv;
int         mismatches = 0;
int         checks_done = 0;
int         n;
cpwg_op_t   ops [0:29];
cpwg_top #(.TICK_CYCLES(32'd8)) cpwg_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .guard_expiry_output_n_o(g_n),
    .dio_output_pins_o(dio_o), .dio_output_pins_oe_o(dio_oe), .dio_input_pins_i(dio_in),
    .led_pins_o(led_o), .led_pins_oe_o(led_oe), .led_pins_i(led_in));
cpwg_host cpwg_host_i (.clk_i(clk_i), .io_rdata_i(io_rdata_o), .io_rvalid_i(io_rvalid_o),
    .io_addr_o(io_addr_i), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i));
// ==========================================================
// helpers
task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
        mismatches++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task results;
    if (mismatches == 0 && checks_done > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
task settle;
    @(posedge clk_i);
    #1;
endtask
// lo of 0 means no expiry may come within bound
task fire(input int bound, input int lo, input int hi);
    n = 0;
    while (g_n !== 1'b0 && n < bound) begin
        settle;
        n++;
    end
    if (lo == 0) begin
        check({7'h0, n == bound}, 8'h01);
    end else begin
        if (n == bound) begin
            mismatches++;
            results;
        end
        check({7'h0, n >= lo && n <= hi}, 8'h01);
    end
endtask
task hold_reset;
    reset_n_i = 1'b0;
    repeat (8) settle;
    check(io_rdata_o, 8'hff);
    check({g_n, dio_oe, 5'h00}, 8'h80);
    check(led_oe, 8'h00);
    reset_n_i = 1'b1;
endtask
initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
end
// ==========================================================
// main sequence
initial begin
    ops = '{'{1'b1, 8'h2f, 8'hff}, '{1'b0, 8'h2e, 8'h87}, '{1'b0, 8'h2e, 8'h07},
        '{1'b0, 8'h2e, 8'h87}, '{1'b1, 8'h2e, 8'hff}, '{1'b0, 8'h2e, 8'h87},
        '{1'b0, 8'h2e, 8'h07}, '{1'b0, 8'h2f, 8'h07}, '{1'b1, 8'h2f, 8'h07},
        '{1'b0, 8'h2e, 8'hec}, '{1'b1, 8'h2e, 8'hec}, '{1'b1, 8'h2f, 8'hff},
        '{1'b0, 8'h2e, 8'h30}, '{1'b0, 8'h2f, 8'h18}, '{1'b0, 8'h2e, 8'hf1},
        '{1'b0, 8'h2f, 8'h02}, '{1'b1, 8'h2f, 8'hb6}, '{1'b1, 8'h40, 8'hff},
        '{1'b0, 8'h2e, 8'hec}, '{1'b0, 8'h2f, 8'hfc}, '{1'b0, 8'h2e, 8'hed},
        '{1'b0, 8'h2f, 8'h01}, '{1'b1, 8'h2f, 8'ha5}, '{1'b0, 8'h2e, 8'he0},
        '{1'b1, 8'h2f, 8'h00}, '{1'b0, 8'h2e, 8'h07}, '{1'b0, 8'h2f, 8'h08},
        '{1'b0, 8'h2e, 8'hf5}, '{1'b0, 8'h2f, 8'h08}, '{1'b1, 8'h2f, 8'h08}};
    hold_reset;
    foreach (ops[i]) begin
        if (ops[i].rd) begin
            cpwg_host_i.rd(ops[i].addr, rv);
            check(rv, ops[i].data);
        end else begin
            cpwg_host_i.wr(ops[i].addr, ops[i].data);
        end
    end
    settle;
    check({dio_oe, dio_o, 4'h0}, 8'he0);
    check(led_oe, 8'h03);
    check(led_o, 8'h01);
    cpwg_host_i.sel(8'h0f);
    cpwg_host_i.cfg_wr(8'he4, 8'h02);
    settle;
    check({dio_oe, dio_o, 4'h0}, 8'h40);
    cpwg_host_i.cfg_wr(8'he4, 8'h00);
    cpwg_host_i.sel(8'h08);
    cpwg_host_i.cfg_wr(8'he4, 8'h01);
    settle;
    check({dio_oe, dio_o, 4'h0}, 8'hf0);
    cpwg_host_i.cfg_wr(8'he4, 8'h00);
    cpwg_host_i.sel(8'h09);
    cpwg_host_i.cfg_wr(8'he2, 8'h10);
    repeat (2) settle;
    check({dio_oe, dio_o, 4'h0}, 8'hc0);
    cpwg_host_i.cfg_wr(8'he2, 8'h00);
    cpwg_host_i.sel(8'h08);
    cpwg_host_i.cfg_wr(8'hf5, 8'h00);
    cpwg_host_i.cfg_wr(8'h30, 8'h01);
    cpwg_host_i.cfg_wr(8'hf1, 8'h02);
    fire(40, 15, 20);
    cpwg_host_i.cfg_rd(8'hf1, rv);
    check(rv, 8'h00);
    cpwg_host_i.cfg_wr(8'hf1, 8'h03);
    repeat (12) settle;
    cpwg_host_i.cfg_wr(8'hf1, 8'h03);
    fire(40, 22, 28);
    repeat (10) settle;
    cpwg_host_i.cfg_wr(8'h30, 8'h00);
    cpwg_host_i.cfg_wr(8'hf1, 8'h01);
    fire(40, 0, 0);
    cpwg_host_i.cfg_wr(8'hf5, 8'h08);
    cpwg_host_i.cfg_wr(8'h30, 8'h01);
    cpwg_host_i.cfg_wr(8'hf1, 8'h01);
    fire(600, 470, 490);
    hold_reset;
    cpwg_host_i.unlock;
    cpwg_host_i.sel(8'h07);
    cpwg_host_i.cfg_rd(8'hec, rv);
    check(rv, 8'hff);
    cpwg_host_i.cfg_wr(8'h30, 8'h10);
    dio_in = 6'h12;
    cpwg_host_i.cfg_rd(8'hf1, rv);
    check(rv, 8'h48);
    cpwg_host_i.wr(8'h2e, 8'haa);
    cpwg_host_i.rd(8'h2f, rv);
    check(rv, 8'hff);
    results;
end
endmodule
bind cpwg_top cpwg_top_assertions cpwg_top_assertions_i (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .guard_expiry_output_n_o(guard_expiry_output_n_o));
`default_nettype wire

// file: design/cpwg_tick_gen.v
/*
 * time-unit tick generator for the countdown guard: one pulse per second,
 * or per minute when minutes are selected.
 * assumes a free running clk_i and that run_i drops whenever the count
 * is reloaded, so each timeout starts on a fresh unit boundary.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpwg_regs.vh"

module cpwg_tick_gen #(
    parameter [31:0] TICK_CYCLES = `CPWG_SEC_CYCLES
) (
    input  wire       clk_i,      // chip clock
    input  wire       reset_n_i,  // async reset, active low
    input  wire       run_i,      // count while high, restart when low
    input  wire       minutes_i,  // unit is minutes
    output reg        tick_o      // one-cycle unit pulse
);

    reg  [31:0] cyc_r;
    reg  [5:0]  sec_r;
    wire        sec_end = (cyc_r == (TICK_CYCLES - 32'h1));

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_r  <= 32'h0;
            sec_r  <= 6'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cyc_r  <= 32'h0;
            sec_r  <= 6'h0;
            tick_o <= 1'b0;
        end else if (sec_end) begin
            cyc_r <= 32'h0;
            if (!minutes_i) begin
                sec_r  <= 6'h0;
                tick_o <= 1'b1;
            end else if (sec_r == (`CPWG_SEC_PER_MIN - 6'h1)) begin
                sec_r  <= 6'h0;
                tick_o <= 1'b1;
            end else begin
                sec_r  <= sec_r + 6'h1;
                tick_o <= 1'b0;
            end
        end else begin
            cyc_r  <= cyc_r + 32'h1;
            tick_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: design/cpwg_top.v
/*
 * configuration port block: index/data port decoder with unlock sequence,
 * logical devices for the countdown guard and the two gpio groups.
 * assumes host strobes are one clock wide and synchronous to clk_i, and
 * that pin levels are resolved outside from the enables.
 */
// Behaviour
// - guard counts a loaded value down and pulses system reset at zero
// - two consecutive 87 writes to index port open configuration access
// - index 07 then data 08 selects the guard logical device
// - guard register 30 enables on 01 and disables on 00
// - unit register picks minutes for 08 and seconds for 00
// - count register f1 holds the timeout in the chosen unit
// - dio data register reads back and drives written output bits to pins
// - led direction bits: 0 output, 1 input, all inputs after reset
// - dio pins 0..1 are outputs, pins 2..7 are inputs
// - led pins 0..1 drive the two dio indicator leds
// - device 7 activate bit 4 enables dio group, bit 3 led group
// - device 9 register holds per-group reset bits 4 and 3
// - device f registers pick open-drain or push-pull per group pin
// - device 8 registers pick gpio or alternate function per pin
`timescale 1ns/1ps
`default_nettype none
`include "cpwg_regs.vh"

module cpwg_top #(
    parameter [31:0] TICK_CYCLES = `CPWG_SEC_CYCLES
) (
    input  wire       clk_i,         // chip clock, 250 MHz
    input  wire       reset_n_i,     // async reset, active low
    input  wire [7:0] io_addr_i,     // host i/o address
    input  wire       io_wr_i,       // host write strobe
    input  wire       io_rd_i,       // host read strobe
    input  wire [7:0] io_wdata_i,    // host write data
    output reg  [7:0] io_rdata_o,    // host read data
    output reg        io_rvalid_o,   // read data valid pulse
    output reg        guard_expiry_output_n_o, // system reset, active low
    output reg  [1:0] dio_output_pins_o,       // dio output level
    output reg  [1:0] dio_output_pins_oe_o,    // dio output enable
    input  wire [5:0] dio_input_pins_i,        // dio input levels
    output reg  [7:0] led_pins_o,    // led group output level
    output reg  [7:0] led_pins_oe_o, // led group output enable
    input  wire [7:0] led_pins_i     // led group pin levels
);

    // ==========================================================
    // decode helper
    function hit;
        input [7:0] ld;
        input [7:0] idx;
        input [7:0] want_ld;
        input [7:0] want_idx;
        begin
            hit = (ld == want_ld) && (idx == want_idx);
        end
    endfunction

    // ==========================================================
    // configuration state
    reg        cfg_mode_r;
    reg        key_half_r;
    reg  [7:0] index_r;
    reg  [7:0] ldn_r;
    reg  [7:0] activate_r;
    reg  [7:0] rst_ctrl_r;
    reg  [7:0] led_dir_r;
    reg  [7:0] led_data_r;
    reg  [7:0] dio_data_r;
    reg  [7:0] led_func_r;
    reg  [7:0] dio_func_r;
    reg  [7:0] led_drive_r;
    reg  [7:0] dio_drive_r;
    reg        guard_en_r;
    reg        guard_min_r;
    reg  [7:0] guard_cnt_r;
    reg  [4:0] expiry_cnt_r;
    reg  [4:0] expiry_cnt_nxt;

    wire wr_index = io_wr_i && (io_addr_i == `CPWG_INDEX_PORT);
    wire wr_data  = io_wr_i && (io_addr_i == `CPWG_DATA_PORT) && cfg_mode_r;
    wire rd_index = io_rd_i && (io_addr_i == `CPWG_INDEX_PORT);
    wire rd_data  = io_rd_i && (io_addr_i == `CPWG_DATA_PORT) && cfg_mode_r;

    wire dio_en  = activate_r[`CPWG_BIT_DIO_GROUP];
    wire led_en  = activate_r[`CPWG_BIT_LED_GROUP];
    wire dio_rst = rst_ctrl_r[`CPWG_BIT_DIO_GROUP];
    wire led_rst = rst_ctrl_r[`CPWG_BIT_LED_GROUP];

    wire wr_ldsel    = wr_data && (index_r == `CPWG_IDX_LD_SELECT);
    wire wr_activate = wr_data && hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_ACTIVATE);
    wire wr_led_dir  = wr_data && hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_LED_DIR);
    wire wr_led_data = wr_data && hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_LED_DATA);
    wire wr_dio_data = wr_data && hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_DIO_DATA);
    wire wr_g_act    = wr_data && hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_ACTIVATE);
    wire wr_g_unit   = wr_data && hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_GUARD_UNIT);
    wire wr_g_cnt    = wr_data && hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_GUARD_COUNT);
    wire wr_led_func = wr_data && hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_LED_FUNC);
    wire wr_dio_func = wr_data && hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_DIO_FUNC);
    wire wr_rst_ctrl = wr_data && hit(ldn_r, index_r, `CPWG_LD_RESET, `CPWG_IDX_RST_CTRL);
    wire wr_led_drv  = wr_data && hit(ldn_r, index_r, `CPWG_LD_DRIVE, `CPWG_IDX_LED_DRIVE);
    wire wr_dio_drv  = wr_data && hit(ldn_r, index_r, `CPWG_LD_DRIVE, `CPWG_IDX_DIO_DRIVE);

    // ==========================================================
    // unlock sequence and index/ldn
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_mode_r <= 1'b0;
            key_half_r <= 1'b0;
            index_r    <= 8'h00;
            ldn_r      <= `CPWG_RST_LD;
        end else begin
            if (!cfg_mode_r && io_wr_i) begin
                // any other write between the two keys breaks the sequence
                if (wr_index && (io_wdata_i == `CPWG_UNLOCK_KEY)) begin
                    cfg_mode_r <= key_half_r;
                    key_half_r <= ~key_half_r;
                end else begin
                    key_half_r <= 1'b0;
                end
            end else if (cfg_mode_r && wr_index) begin
                if (io_wdata_i == `CPWG_LOCK_KEY) begin
                    cfg_mode_r <= 1'b0;
                end else begin
                    index_r <= io_wdata_i;
                end
            end
            if (wr_ldsel) begin
                ldn_r <= io_wdata_i;
            end
        end
    end

    // ==========================================================
    // gpio group registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            activate_r  <= `CPWG_RST_ACTIVATE;
            rst_ctrl_r  <= `CPWG_RST_RST_CTRL;
            led_dir_r   <= `CPWG_RST_LED_DIR;
            led_data_r  <= `CPWG_RST_LED_DATA;
            dio_data_r  <= `CPWG_RST_DIO_DATA;
            led_func_r  <= `CPWG_RST_FUNC;
            dio_func_r  <= `CPWG_RST_FUNC;
            led_drive_r <= `CPWG_RST_DRIVE;
            dio_drive_r <= `CPWG_RST_DRIVE;
        end else begin
            if (wr_activate) begin
                activate_r <= io_wdata_i;
            end
            if (wr_rst_ctrl) begin
                rst_ctrl_r <= io_wdata_i;
            end
            // a set group reset bit holds that group's settings at default
            if (dio_rst) begin
                dio_data_r  <= `CPWG_RST_DIO_DATA;
                dio_func_r  <= `CPWG_RST_FUNC;
                dio_drive_r <= `CPWG_RST_DRIVE;
            end else begin
                if (wr_dio_data) begin
                    dio_data_r <= io_wdata_i;
                end
                if (wr_dio_func) begin
                    dio_func_r <= io_wdata_i;
                end
                if (wr_dio_drv) begin
                    dio_drive_r <= io_wdata_i;
                end
            end
            if (led_rst) begin
                led_dir_r   <= `CPWG_RST_LED_DIR;
                led_data_r  <= `CPWG_RST_LED_DATA;
                led_func_r  <= `CPWG_RST_FUNC;
                led_drive_r <= `CPWG_RST_DRIVE;
            end else begin
                if (wr_led_dir) begin
                    led_dir_r <= io_wdata_i;
                end
                if (wr_led_data) begin
                    led_data_r <= io_wdata_i;
                end
                if (wr_led_func) begin
                    led_func_r <= io_wdata_i;
                end
                if (wr_led_drv) begin
                    led_drive_r <= io_wdata_i;
                end
            end
        end
    end

    // ==========================================================
    // countdown guard
    wire guard_run = guard_en_r && (guard_cnt_r != 8'h00) && !wr_g_cnt && !wr_g_act;
    wire unit_tick;
    wire expire = guard_run && unit_tick && (guard_cnt_r == 8'h01);

    cpwg_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (guard_run),
        .minutes_i (guard_min_r),
        .tick_o    (unit_tick)
    );

    always @* begin
        expiry_cnt_nxt = expiry_cnt_r;
        if (expire) begin
            expiry_cnt_nxt = `CPWG_EXPIRY_CYCLES;
        end else if (expiry_cnt_r != 5'h0) begin
            expiry_cnt_nxt = expiry_cnt_r - 5'h1;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            guard_en_r   <= 1'b0;
            guard_min_r  <= 1'b0;
            guard_cnt_r  <= `CPWG_RST_GUARD_CNT;
            expiry_cnt_r <= 5'h0;
        end else begin
            if (wr_g_act) begin
                // only the two documented codes change the enable
                if (io_wdata_i == `CPWG_GUARD_ON) begin
                    guard_en_r <= 1'b1;
                end else if (io_wdata_i == `CPWG_GUARD_OFF) begin
                    guard_en_r <= 1'b0;
                end
            end
            if (wr_g_unit) begin
                guard_min_r <= (io_wdata_i == `CPWG_UNIT_MINUTES);
            end
            if (wr_g_cnt) begin
                guard_cnt_r <= io_wdata_i;
            end else if (guard_run && unit_tick) begin
                guard_cnt_r <= guard_cnt_r - 8'h01;
            end
            expiry_cnt_r <= expiry_cnt_nxt;
        end
    end

    // ==========================================================
    // pin drive, one slice per pin
    wire [1:0] dio_lvl_w;
    wire [1:0] dio_oe_w;
    wire [7:0] led_lvl_w;
    wire [7:0] led_oe_w;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_dio
            wire val = dio_func_r[g] ? guard_expiry_output_n_o : dio_data_r[g];
            // open drain only ever pulls low
            assign dio_lvl_w[g] = dio_drive_r[g] ? 1'b0 : val;
            assign dio_oe_w[g]  = dio_en && (!dio_drive_r[g] || !val);
        end
        for (g = 0; g < 8; g = g + 1) begin : g_led
            wire val = led_func_r[g] ? guard_expiry_output_n_o : led_data_r[g];
            assign led_lvl_w[g] = led_drive_r[g] ? 1'b0 : val;
            assign led_oe_w[g]  = led_en && !led_dir_r[g] &&
                                  (!led_drive_r[g] || !val);
        end
    endgenerate

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            guard_expiry_output_n_o <= 1'b1;
            dio_output_pins_o       <= 2'h0;
            dio_output_pins_oe_o    <= 2'h0;
            led_pins_o              <= 8'h00;
            led_pins_oe_o           <= 8'h00;
        end else begin
            guard_expiry_output_n_o <= (expiry_cnt_nxt == 5'h0);
            dio_output_pins_o       <= dio_lvl_w;
            dio_output_pins_oe_o    <= dio_oe_w;
            led_pins_o              <= led_lvl_w;
            led_pins_oe_o           <= led_oe_w;
        end
    end

    // ==========================================================
    // read path
    reg  [7:0] rd_mux;
    wire [7:0] dio_rd = dio_en ? {dio_input_pins_i, dio_data_r[1:0]} : 8'h00;
    wire [7:0] led_rd = led_en ? ((led_pins_i & led_dir_r) | (led_data_r & ~led_dir_r))
                               : 8'h00;

    always @* begin
        rd_mux = 8'h00;
        if (index_r == `CPWG_IDX_LD_SELECT) begin
            rd_mux = ldn_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_ACTIVATE)) begin
            rd_mux = activate_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_LED_DIR)) begin
            rd_mux = led_dir_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_LED_DATA)) begin
            rd_mux = led_rd;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GPIO, `CPWG_IDX_DIO_DATA)) begin
            rd_mux = dio_rd;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_ACTIVATE)) begin
            rd_mux = {7'h00, guard_en_r};
        end else if (hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_GUARD_UNIT)) begin
            rd_mux = guard_min_r ? `CPWG_UNIT_MINUTES : `CPWG_UNIT_SECONDS;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_GUARD_COUNT)) begin
            rd_mux = guard_cnt_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_LED_FUNC)) begin
            rd_mux = led_func_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_GUARD, `CPWG_IDX_DIO_FUNC)) begin
            rd_mux = dio_func_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_RESET, `CPWG_IDX_RST_CTRL)) begin
            rd_mux = rst_ctrl_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_DRIVE, `CPWG_IDX_LED_DRIVE)) begin
            rd_mux = led_drive_r;
        end else if (hit(ldn_r, index_r, `CPWG_LD_DRIVE, `CPWG_IDX_DIO_DRIVE)) begin
            rd_mux = dio_drive_r;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            io_rdata_o  <= `CPWG_IDLE_RDATA;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            if (rd_index && cfg_mode_r) begin
                io_rdata_o <= index_r;
            end else if (rd_data) begin
                io_rdata_o <= rd_mux;
            end else if (io_rd_i) begin
                // locked or foreign address: floating-bus value
                io_rdata_o <= `CPWG_IDLE_RDATA;
            end
        end
    end

endmodule
`default_nettype wire

// file: pkg/cpwg_regs.vh
/*
 * constants of the configuration port block: port addresses, unlock and
 * lock bytes, logical device numbers, register indices, field positions,
 * reset values and timing counts.
 * assumes inclusion by its bare name from every design file that needs it.
 */
`ifndef CPWG_REGS_VH
`define CPWG_REGS_VH

// ==========================================================
// host i/o ports and key bytes
`define CPWG_INDEX_PORT      8'h2e
`define CPWG_DATA_PORT       8'h2f
`define CPWG_UNLOCK_KEY      8'h87
`define CPWG_LOCK_KEY        8'haa
`define CPWG_IDLE_RDATA      8'hff

// ==========================================================
// logical device numbers
`define CPWG_LD_GPIO         8'h07
`define CPWG_LD_GUARD        8'h08
`define CPWG_LD_RESET        8'h09
`define CPWG_LD_DRIVE        8'h0f

// ==========================================================
// register indices
`define CPWG_IDX_LD_SELECT   8'h07
`define CPWG_IDX_ACTIVATE    8'h30
`define CPWG_IDX_LED_DIR     8'hec
`define CPWG_IDX_LED_DATA    8'hed
`define CPWG_IDX_DIO_DATA    8'hf1
`define CPWG_IDX_GUARD_UNIT  8'hf5
`define CPWG_IDX_GUARD_COUNT 8'hf1
`define CPWG_IDX_RST_CTRL    8'he2
`define CPWG_IDX_LED_FUNC    8'he3
`define CPWG_IDX_DIO_FUNC    8'he4
`define CPWG_IDX_LED_DRIVE   8'he3
`define CPWG_IDX_DIO_DRIVE   8'he4

// ==========================================================
// field positions and encodings
`define CPWG_BIT_DIO_GROUP   4
`define CPWG_BIT_LED_GROUP   3
`define CPWG_GUARD_ON        8'h01
`define CPWG_GUARD_OFF       8'h00
`define CPWG_UNIT_MINUTES    8'h08
`define CPWG_UNIT_SECONDS    8'h00

// ==========================================================
// reset values
`define CPWG_RST_LD          8'h00
`define CPWG_RST_ACTIVATE    8'h00
`define CPWG_RST_LED_DIR     8'hff
`define CPWG_RST_LED_DATA    8'h00
`define CPWG_RST_DIO_DATA    8'h00
`define CPWG_RST_FUNC        8'h00
`define CPWG_RST_DRIVE       8'h00
`define CPWG_RST_RST_CTRL    8'h00
`define CPWG_RST_GUARD_CNT   8'h00

// ==========================================================
// timing
`define CPWG_CLK_PERIOD_NS   32'd4
`define CPWG_SECOND_NS       32'd1000000000
`define CPWG_SEC_CYCLES      (`CPWG_SECOND_NS / `CPWG_CLK_PERIOD_NS)
`define CPWG_SEC_PER_MIN     6'd60
`define CPWG_EXPIRY_CYCLES   5'd16

`endif
